// ### verilog/scalr_pkg.sv
package scalr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PUMP_CONFIG = 6'h23;
  localparam logic [5:0] OFS_VCO_CURRENT = 6'h24;
  localparam logic [5:0] OFS_COARSE_TUNE = 6'h25;
  localparam logic [5:0] OFS_CAL_CONTROL = 6'h26;
  localparam logic [5:0] OFS_RC_OSC_UPPER = 6'h27;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PUMP_CFG_MSB = 7;
  localparam int PUMP_CFG_LSB = 6;
  localparam int PUMP_EN_MSB = 5;
  localparam int PUMP_EN_LSB = 4;
  localparam int PUMP_CODE_MSB = 3;
  localparam int PUMP_CODE_LSB = 0;
  localparam int VCO_HIGH_BIT = 5;
  localparam int VCO_CUR_MSB = 4;
  localparam int COARSE_MSB = 5;
  localparam int CAL_CTRL_MSB = 6;
  localparam int RC_OSC_MSB = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_PUMP_CFG = 2'h2;
  localparam logic [1:0] RST_PUMP_EN = 2'h2;
  localparam logic [3:0] RST_PUMP_CODE = 4'h9;
  localparam logic RST_VCO_HIGH = 1'b0;
  localparam logic [4:0] RST_VCO_CUR = 5'h0A;
  localparam logic [5:0] RST_COARSE = 6'h20;
  localparam logic [6:0] RST_CAL_CTRL = 7'h0D;
  localparam logic [6:0] RST_RC_OSC = 7'h41;

  // ----------------------------------------------------------------
  // value meaning "pump calibration stage off"
  // ----------------------------------------------------------------
  localparam logic [1:0] PUMP_EN_OFF = 2'h0;

endpackage

// ### verilog/scalr_reset_sync.sv
`timescale 1ns/10ps
module scalr_reset_sync
(
  // clock and raw reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // released reset
  output logic rst_sync_n
);

  logic stage_ff;

  // ----------------------------------------------------------------
  // two-stage release, assert stays asynchronous
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      stage_ff <= 1'b1;
      rst_sync_n <= stage_ff;
    end
  end

endmodule // scalr_reset_sync

// ### verilog/scalr_synth_cal_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - pump enable field zero makes calibration skip the charge pump stage.
// - low nibble of first register is the exponential pump current code.
// - first register resets to config 2, pump enable 2, code 1001.
// - host-written result values are used instead of running a calibration.
// - bit 5 of second register picks high VCO core; resets to zero.
// - five-bit VCO current result and override value, resets to ten.
// - six-bit coarse-tune capacitor array result, resets to thirty-two.
// - seven-bit calibration control field read/write, resets to thirteen.
// - register 0x27 holds seven-bit RC oscillator config, resets to 65.
module scalr_synth_cal_regs
  import scalr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port from serial control interface
  input wire logic reg_wr_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // calibration engine side
  input wire logic cal_start,
  input wire logic cal_done,
  input wire logic [3:0] cal_pump_code,
  input wire logic [4:0] cal_vco_current,
  input wire logic [5:0] cal_coarse_tune,
  output logic cal_pump_stage_run,
  // settings to the synthesizer
  output logic [1:0] synth_pump_cfg,
  output logic [3:0] synth_pump_code,
  output logic vco_high_core_select,
  output logic [4:0] synth_vco_current,
  output logic [5:0] synth_coarse_tune,
  output logic [6:0] synth_cal_control,
  output logic [6:0] rc_osc_config
);

  logic rst_sync_n;
  logic [1:0] pump_cfg_ff;
  logic [1:0] pump_cal_stage_enable_ff;
  logic [3:0] pump_code_ff;
  logic vco_high_ff;
  logic [4:0] vco_cur_ff;
  logic [5:0] coarse_ff;
  logic [6:0] cal_ctrl_ff;
  logic [6:0] rc_osc_ff;
  logic pump_run_ff;
  logic [7:0] nxt_rdata;
  logic nxt_hit;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  scalr_reset_sync u_reset_sync
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  function automatic logic wr_hit(input logic [5:0] ofs);
    wr_hit = reg_wr_en && (reg_addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // pump configuration register
  // ----------------------------------------------------------------
  // host writes take priority over a finishing calibration: a restored
  // hop value must never be clobbered by a stale result
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pump_cfg_ff <= RST_PUMP_CFG;
      pump_cal_stage_enable_ff <= RST_PUMP_EN;
      pump_code_ff <= RST_PUMP_CODE;
    end
    else if (wr_hit(OFS_PUMP_CONFIG))
    begin
      pump_cfg_ff <= reg_wdata[PUMP_CFG_MSB:PUMP_CFG_LSB];
      pump_cal_stage_enable_ff <= reg_wdata[PUMP_EN_MSB:PUMP_EN_LSB];
      pump_code_ff <= reg_wdata[PUMP_CODE_MSB:PUMP_CODE_LSB];
    end
    else if (cal_done && pump_run_ff)
    begin
      pump_code_ff <= cal_pump_code;
    end
  end

  // ----------------------------------------------------------------
  // vco current register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      vco_high_ff <= RST_VCO_HIGH;
      vco_cur_ff <= RST_VCO_CUR;
    end
    else if (wr_hit(OFS_VCO_CURRENT))
    begin
      vco_high_ff <= reg_wdata[VCO_HIGH_BIT];
      vco_cur_ff <= reg_wdata[VCO_CUR_MSB:0];
    end
    else if (cal_done)
    begin
      vco_cur_ff <= cal_vco_current;
    end
  end

  // ----------------------------------------------------------------
  // coarse tune register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      coarse_ff <= RST_COARSE;
    end
    else if (wr_hit(OFS_COARSE_TUNE))
    begin
      coarse_ff <= reg_wdata[COARSE_MSB:0];
    end
    else if (cal_done)
    begin
      coarse_ff <= cal_coarse_tune;
    end
  end

  // ----------------------------------------------------------------
  // control and rc oscillator registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cal_ctrl_ff <= RST_CAL_CTRL;
      rc_osc_ff <= RST_RC_OSC;
    end
    else
    begin
      if (wr_hit(OFS_CAL_CONTROL))
      begin
        cal_ctrl_ff <= reg_wdata[CAL_CTRL_MSB:0];
      end
      if (wr_hit(OFS_RC_OSC_UPPER))
      begin
        rc_osc_ff <= reg_wdata[RC_OSC_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pump stage decision, latched at calibration start
  // ----------------------------------------------------------------
  // latched so a mid-calibration write cannot change which results load
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pump_run_ff <= 1'b0;
    end
    else if (cal_start)
    begin
      pump_run_ff <= (pump_cal_stage_enable_ff != PUMP_EN_OFF);
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = 8'h00;
    nxt_hit = 1'b1;
    unique case (reg_addr)
      OFS_PUMP_CONFIG: nxt_rdata = {pump_cfg_ff, pump_cal_stage_enable_ff, pump_code_ff};
      OFS_VCO_CURRENT: nxt_rdata = {2'h0, vco_high_ff, vco_cur_ff};
      OFS_COARSE_TUNE: nxt_rdata = {2'h0, coarse_ff};
      OFS_CAL_CONTROL: nxt_rdata = {1'b0, cal_ctrl_ff};
      OFS_RC_OSC_UPPER: nxt_rdata = {1'b0, rc_osc_ff};
      default: nxt_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end
    else
    begin
      reg_rdata <= nxt_rdata;
      reg_hit <= nxt_hit;
    end
  end

  // ----------------------------------------------------------------
  // settings to the synthesizer
  // ----------------------------------------------------------------
  // the analog side applies code as I0 * 2^(code/4); stored values drive it
  assign synth_pump_cfg = pump_cfg_ff;
  assign synth_pump_code = pump_code_ff;
  assign vco_high_core_select = vco_high_ff;
  assign synth_vco_current = vco_cur_ff;
  assign synth_coarse_tune = coarse_ff;
  assign synth_cal_control = cal_ctrl_ff;
  assign rc_osc_config = rc_osc_ff;
  assign cal_pump_stage_run = (pump_cal_stage_enable_ff != PUMP_EN_OFF);

endmodule // scalr_synth_cal_regs

// ### verif/scalr_synth_cal_regs_asserts.sv
`timescale 1ns/10ps
module scalr_synth_cal_regs_chk
  import scalr_pkg::*;
(
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic cal_done,
  input wire logic [4:0] cal_vco_current,
  input wire logic [5:0] cal_coarse_tune,
  input wire logic cal_pump_stage_run,
  input wire logic vco_high_core_select,
  input wire logic [4:0] synth_vco_current,
  input wire logic [5:0] synth_coarse_tune,
  input wire logic [6:0] synth_cal_control,
  input wire logic [6:0] rc_osc_config
);
  // ----------------------------------------
  // write, calibration and read relations
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a); reg_wr_en && reg_addr == a; endsequence
  sequence s_cal; cal_done && !reg_wr_en; endsequence
  property p_ctrl; s_wr(OFS_CAL_CONTROL) |=> synth_cal_control == $past(reg_wdata[6:0]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write lost");
  property p_rc; s_wr(OFS_RC_OSC_UPPER) |=> rc_osc_config == $past(reg_wdata[6:0]); endproperty
  a_rc: assert property (p_rc) else $error("rc write lost");
  property p_vco; s_wr(OFS_VCO_CURRENT) |=> {vco_high_core_select, synth_vco_current} == $past(reg_wdata[5:0]);
  endproperty
  a_vco: assert property (p_vco) else $error("vco write lost");
  property p_coarse; s_wr(OFS_COARSE_TUNE) |=> synth_coarse_tune == $past(reg_wdata[5:0]); endproperty
  a_coarse: assert property (p_coarse) else $error("coarse write lost");
  property p_stage; s_wr(OFS_PUMP_CONFIG) |=> cal_pump_stage_run == ($past(reg_wdata[5:4]) != PUMP_EN_OFF);
  endproperty
  a_stage: assert property (p_stage) else $error("pump stage decision wrong");
  property p_load; s_cal |=> synth_vco_current == $past(cal_vco_current)
    && synth_coarse_tune == $past(cal_coarse_tune); endproperty
  a_load: assert property (p_load) else $error("results not loaded");
  property p_miss; !(reg_addr inside {[6'h23:6'h27]}) |=> !reg_hit && reg_rdata == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
  // the guard on reg_hit keeps this quiet while the synchronised reset drains
  property p_rd; reg_hit && $past(reg_addr) == OFS_CAL_CONTROL && !$past(reg_wr_en)
    |-> reg_rdata == {1'b0, $past(synth_cal_control)}; endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
endmodule // scalr_synth_cal_regs_chk

// ### verif/synth_calibration_registers_tb_top.sv
`timescale 1ns/10ps
module synth_calibration_registers_tb_top
  import scalr_pkg::*;
;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic cal_start = 1'b0;
  logic cal_done = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] cal_pump_code = 4'h0;
  logic [4:0] cal_vco_current = 5'h00;
  logic [5:0] cal_coarse_tune = 6'h00;
  logic [7:0] reg_rdata;
  logic reg_hit, cal_pump_stage_run, vco_high_core_select;
  logic [1:0] synth_pump_cfg;
  logic [3:0] synth_pump_code;
  logic [4:0] synth_vco_current;
  logic [5:0] synth_coarse_tune;
  logic [6:0] synth_cal_control, rc_osc_config;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] rst_val [5] = '{8'hA9, 8'h0A, 8'h20, 8'h0D, 8'h41};
  logic [7:0] mask [5] = '{8'hFF, 8'h3F, 8'h3F, 8'h7F, 8'h7F};
  logic [7:0] pat [2] = '{8'hFF, 8'h5A};
  always #12.5 sys_clk = ~sys_clk;
  scalr_synth_cal_regs i_dut (.sys_clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .cal_start, .cal_done, .cal_pump_code, .cal_vco_current, .cal_coarse_tune, .cal_pump_stage_run,
    .synth_pump_cfg, .synth_pump_code, .vco_high_core_select, .synth_vco_current, .synth_coarse_tune,
    .synth_cal_control, .rc_osc_config);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    reg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(reg_rdata, exp);
    chk({7'h00, reg_hit}, {7'h00, a inside {[OFS_PUMP_CONFIG:OFS_RC_OSC_UPPER]}});
    @(posedge sys_clk);
  endtask
  task automatic cal(input logic [3:0] p, input logic [4:0] v, input logic [5:0] c);
    cal_start <= 1'b1;
    @(posedge sys_clk);
    cal_start <= 1'b0;
    cal_pump_code <= p;
    cal_vco_current <= v;
    cal_coarse_tune <= c;
    cal_done <= 1'b1;
    @(posedge sys_clk);
    cal_done <= 1'b0;
    @(posedge sys_clk);
  endtask
  // the extra edges cover the two-flop release before the first write
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    do_reset();
    for (int i = 0; i < 5; i++) rd(OFS_PUMP_CONFIG + 6'(i), rst_val[i]);
    rd(6'h22, 8'h00);
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 5; i++)
      begin
        wr(OFS_PUMP_CONFIG + 6'(i), pat[j]);
        rd(OFS_PUMP_CONFIG + 6'(i), pat[j] & mask[i]);
      end
    wr(6'h28, 8'hFF);
    rd(OFS_RC_OSC_UPPER, 8'h5A);
    for (int e = 0; e < 4; e++)
    begin
      wr(OFS_PUMP_CONFIG, {2'h2, 2'(e), 4'h9});
      chk({7'h00, cal_pump_stage_run}, {7'h00, e != 0});
    end
    cal(4'h5, 5'h13, 6'h2A);
    rd(OFS_PUMP_CONFIG, 8'hB5);
    rd(OFS_VCO_CURRENT, 8'h13);
    rd(OFS_COARSE_TUNE, 8'h2A);
    wr(OFS_PUMP_CONFIG, 8'h89);
    cal(4'h3, 5'h07, 6'h11);
    rd(OFS_PUMP_CONFIG, 8'h89);
    rd(OFS_VCO_CURRENT, 8'h07);
    wr(OFS_VCO_CURRENT, 8'h33);
    wr(OFS_COARSE_TUNE, 8'h15);
    chk({2'h0, vco_high_core_select, synth_vco_current}, 8'h33);
    chk({2'h0, synth_coarse_tune}, 8'h15);
    // host side band settings: upper nibble 0xA and control 0x07 must stick
    wr(OFS_PUMP_CONFIG, 8'hA3);
    rd(OFS_PUMP_CONFIG, 8'hA3);
    wr(OFS_CAL_CONTROL, 8'h07);
    rd(OFS_CAL_CONTROL, 8'h07);
    chk({1'b0, synth_cal_control}, 8'h07);
    do_reset();
    chk({4'h0, synth_pump_code}, 8'h09);
    chk({6'h00, synth_pump_cfg}, 8'h02);
    chk({1'b0, synth_cal_control}, 8'h0D);
    rd(OFS_RC_OSC_UPPER, 8'h41);
    wrap_up();
  end
endmodule // synth_calibration_registers_tb_top
bind scalr_synth_cal_regs scalr_synth_cal_regs_chk i_chk (.sys_clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_hit, .cal_done, .cal_vco_current, .cal_coarse_tune, .cal_pump_stage_run, .vco_high_core_select,
  .synth_vco_current, .synth_coarse_tune, .synth_cal_control, .rc_osc_config);
